// ===== hw/vref_control.sv
// voltage reference control: one control register over axi4-lite
// assumes port_a_bit2_dir comes from logic on mclk, so it is not synchronised
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module vref_control
  import vref_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port a bit 2 direction, 1 = input
  input wire logic port_a_bit2_dir,
  // to the analog ladder and pin switch
  output logic ladder_power_enable,
  output logic range_low,
  output logic [3:0] tap_code,
  output logic pin_output_enable,
  output logic port_a_bit2_pin_drive,
  output logic [LEVEL_W-1:0] ref_level
);
  // write channel state
  logic aw_held; // address captured, waiting for data
  logic w_held; // data captured, waiting for address
  logic [ADDR_W-1:0] aw_addr; // captured write address
  logic [7:0] w_byte; // captured low data byte
  logic w_lane0; // captured strobe for byte lane 0
  logic next_aw_held;
  logic next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [7:0] next_w_byte;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  // control register fields
  logic power; // ladder power
  logic pin_en; // pin routing
  logic range_sel; // 1 = low range
  logic [3:0] tap; // ladder tap
  logic next_power;
  logic next_pin_en;
  logic next_range_sel;
  logic [3:0] next_tap;
  // read channel state
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  // decoder results registered for the outputs
  logic next_drive;
  logic [LEVEL_W-1:0] next_level;
  logic [7:0] ctrl_word; // control register as read back

  ref_ctrl_if dec_if ();

  ladder_decoder u_dec (
    .bus(dec_if.dec)
  );

  // our own fields and port_a_bit2_dir feed the decoder; no comparator mode input exists
  assign dec_if.power = power;
  assign dec_if.pin_en = pin_en;
  assign dec_if.range_low = range_sel;
  assign dec_if.tap = tap;
  assign dec_if.pin_is_input = port_a_bit2_dir;

  // read image; bit 4 is not stored and always reads zero
  always_comb begin
    ctrl_word = 8'h00;
    ctrl_word[POWER_BIT] = power;
    ctrl_word[PIN_EN_BIT] = pin_en;
    ctrl_word[RANGE_BIT] = range_sel;
    ctrl_word[TAP_MSB:TAP_LSB] = tap;
  end

  // write path: address and data in either order, then one response
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_power = power;
    next_pin_en = pin_en;
    next_range_sel = range_sel;
    next_tap = tap;
    // response taken, slot free again
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // capture address
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    // capture data, only lane 0 carries implemented bits
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_byte = wdata[7:0];
      next_w_lane0 = wstrb[0];
    end
    // commit once both halves are held and no response is pending
    if (aw_held && w_held && !bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr == REF_CTRL_ADDR) begin
        next_bresp = RESP_OKAY;
        if (w_lane0) begin
          // bit 4 of the written byte is dropped
          next_power = w_byte[POWER_BIT];
          next_pin_en = w_byte[PIN_EN_BIT];
          next_range_sel = w_byte[RANGE_BIT];
          next_tap = w_byte[TAP_MSB:TAP_LSB];
        end
      end else if (aw_addr == REF_STATUS_ADDR) begin
        // status is read-only; write ignored but acknowledged
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR; // unmapped
      end
    end
    // ready falls as soon as a half is held, so nothing is overwritten
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // write path registers; rstn is the device reset, sleep wake has no path here
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      power <= REF_CTRL_RESET[POWER_BIT];
      pin_en <= REF_CTRL_RESET[PIN_EN_BIT];
      range_sel <= REF_CTRL_RESET[RANGE_BIT];
      tap <= REF_CTRL_RESET[TAP_MSB:TAP_LSB];
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      // fields change only by a bus write; wake events never reach them
      power <= next_power;
      pin_en <= next_pin_en;
      range_sel <= next_range_sel;
      tap <= next_tap;
    end
  end

  // read path: one read at a time, data answered the edge after the address
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      if (araddr == REF_CTRL_ADDR) begin
        next_rdata = {24'h000000, ctrl_word};
      end else if (araddr == REF_STATUS_ADDR) begin
        // live view of what the ladder and pin are doing
        next_rdata = 32'h00000000;
        next_rdata[LEVEL_W-1:0] = ref_level;
        next_rdata[STAT_DRIVE_BIT] = port_a_bit2_pin_drive;
        next_rdata[STAT_POWER_BIT] = ladder_power_enable;
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = RESP_SLVERR; // unmapped
      end
    end
    next_arready = !next_rvalid;
  end

  // read path registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  // registered decoder results; one cycle behind the fields
  always_comb begin
    next_drive = dec_if.drive;
    next_level = dec_if.level;
  end

  // outputs; analog switches see clean flop levels, never decode glitches
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ladder_power_enable <= 1'b0;
      range_low <= 1'b0;
      tap_code <= 4'h0;
      pin_output_enable <= 1'b0;
      port_a_bit2_pin_drive <= 1'b0;
      ref_level <= '0;
    end else begin
      ladder_power_enable <= power;
      range_low <= range_sel;
      tap_code <= tap;
      pin_output_enable <= pin_en;
      port_a_bit2_pin_drive <= next_drive;
      ref_level <= next_level;
    end
  end
endmodule

// ===== inc/vref_pkg.sv
// constants shared by the voltage reference control block and its decoder
// assumes a 32-bit axi4-lite bus with word-aligned registers
package vref_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] REF_CTRL_INDEX = 8'h9F;
  localparam logic [7:0] REF_STATUS_INDEX = 8'hA0;
  localparam int ADDR_W = 12;
  localparam logic [11:0] REF_CTRL_ADDR = {2'h0, REF_CTRL_INDEX, 2'h0};
  localparam logic [11:0] REF_STATUS_ADDR = {2'h0, REF_STATUS_INDEX, 2'h0};
  // control register field positions
  localparam int POWER_BIT = 7;
  localparam int PIN_EN_BIT = 6;
  localparam int RANGE_BIT = 5;
  localparam int TAP_MSB = 3;
  localparam int TAP_LSB = 0;
  // status register field positions
  localparam int STAT_DRIVE_BIT = 8;
  localparam int STAT_POWER_BIT = 9;
  // value after any device reset
  localparam logic [7:0] REF_CTRL_RESET = 8'h00;
  // number of distinct taps per range
  localparam int TAP_COUNT = 16;
  // level is reported in 1/96 of supply, common to both ranges
  localparam int LEVEL_W = 7;
  localparam logic [LEVEL_W-1:0] HIGH_RANGE_BASE = 7'h08;
  localparam logic [LEVEL_W-1:0] HIGH_RANGE_SCALE = 7'h03;
  localparam logic [LEVEL_W-1:0] LOW_RANGE_SCALE = 7'h04;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== inc/ref_ctrl_if.sv
// carries control fields into the ladder decoder and its results back
// assumes one clock domain; the decoder is purely combinational
`timescale 1ns/1ps
interface ref_ctrl_if;
  import vref_pkg::*;
  logic power; // ladder powered
  logic pin_en; // route reference to the pin
  logic range_low; // 1 = low range
  logic [3:0] tap; // ladder tap
  logic pin_is_input; // port a bit 2 direction is input
  logic [LEVEL_W-1:0] level; // level in 1/96 of supply
  logic drive; // reference drives the pin
  modport ctrl (output power, output pin_en, output range_low, output tap,
                output pin_is_input, input level, input drive);
  modport dec (input power, input pin_en, input range_low, input tap,
               input pin_is_input, output level, output drive);
endinterface

// ===== hw/ladder_decoder.sv
// maps the control fields to a ladder level and a pin drive decision
// assumes fields come from registers on the same clock
`timescale 1ns/1ps
module ladder_decoder
  import vref_pkg::*;
(
  ref_ctrl_if.dec bus
);
  // level from tap and range; powered-down ladder reads as zero
  always_comb begin
    if (!bus.power) begin
      bus.level = '0;
    end else if (bus.range_low) begin
      bus.level = LOW_RANGE_SCALE * {3'h0, bus.tap}; // tap/24 of supply
    end else begin
      // quarter of supply plus tap/32 of supply
      bus.level = HIGH_RANGE_SCALE * (HIGH_RANGE_BASE + {3'h0, bus.tap});
    end
  end

  // the pin only sees the reference when it is an input and routing is on
  always_comb begin
    bus.drive = bus.power && bus.pin_en && bus.pin_is_input;
  end
endmodule

// ===== testbench/vref_control_properties.sv
// port-level assertions for the reference control block
// assumes it is bound onto vref_control, one mclk domain
`timescale 1ns/1ps
module vref_control_checker
  import vref_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic port_a_bit2_dir,
  input wire logic ladder_power_enable,
  input wire logic range_low,
  input wire logic pin_output_enable,
  input wire logic port_a_bit2_pin_drive,
  input wire logic [3:0] tap_code,
  input wire logic [LEVEL_W-1:0] ref_level
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // drive lags the direction bit by one cycle
  chk_pin_drive_gate: assert property (
    port_a_bit2_pin_drive == (ladder_power_enable && pin_output_enable && $past(port_a_bit2_dir)))
    else $error("pin drive wrong");
  chk_level_off: assert property (!ladder_power_enable |-> ref_level == 0)
    else $error("level while off");
  chk_level_high: assert property (ladder_power_enable && !range_low |-> ref_level == 3 * (8 + tap_code))
    else $error("high range level");
  chk_level_low: assert property (ladder_power_enable && range_low |-> ref_level == 4 * tap_code)
    else $error("low range level");
  // fields only move after a committed write
  chk_fields_stay: assert property (
    $changed({ladder_power_enable, pin_output_enable, range_low, tap_code}) |-> $past(bvalid))
    else $error("field changed without write");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("rvalid dropped");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("no write response");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("no read data");
  chk_read_single: assert property (rvalid |-> !arready)
    else $error("second read open");
  cover property (bvalid && !bready);
  cover property (port_a_bit2_pin_drive);
  cover property (ladder_power_enable && range_low);
endmodule
bind vref_control vref_control_checker vref_control_checker_i (.mclk, .rstn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .port_a_bit2_dir, .ladder_power_enable, .range_low,
  .pin_output_enable, .port_a_bit2_pin_drive, .tap_code, .ref_level);

// ===== testbench/tb.sv
// self-checking bench for the reference control block
// assumes the checker is bound in; bench is the only bus master
`timescale 1ns/1ps
module tb;
  import vref_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, port_a_bit2_dir = 1'b0;
  logic [ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF, tap_code;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid;
  logic ladder_power_enable, range_low, pin_output_enable, port_a_bit2_pin_drive;
  logic [LEVEL_W-1:0] ref_level;
  int error_cnt = 0, n_checks = 0;
  vref_control vref_control_i (.mclk, .rstn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .port_a_bit2_dir, .ladder_power_enable, .range_low, .tap_code, .pin_output_enable,
    .port_a_bit2_pin_drive, .ref_level);
  initial forever #50 mclk = ~mclk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // write: address and data offered together, bready raised late to stall
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    bready <= 1'b1;
    // response taken at the edge that sees bready and bvalid together
    do @(posedge mclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    // data taken at the edge that sees rready and rvalid together
    do @(posedge mclk); while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // outputs lag the fields by a cycle
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_fields;
    port_a_bit2_dir <= 1'b1;
    wr(REF_CTRL_ADDR, 32'hFF, 4'h1, r);
    cmp(r, RESP_OKAY);
    settle;
    rd(REF_CTRL_ADDR, d, r);
    cmp(d, 32'hEF);
    cmp(ref_level, 60);
    cmp(port_a_bit2_pin_drive, 1);
    cmp({ladder_power_enable, pin_output_enable}, 2'h3);
    rd(REF_STATUS_ADDR, d, r);
    cmp(d, 32'h33C);
    port_a_bit2_dir <= 1'b0;
    settle;
    cmp(port_a_bit2_pin_drive, 0);
  endtask
  task automatic t_levels;
    for (int t = 0; t < TAP_COUNT; t++) begin
      wr(REF_CTRL_ADDR, 32'h80 | t, 4'h1, r);
      settle;
      cmp(ref_level, 3 * (8 + t));
      wr(REF_CTRL_ADDR, 32'hA0 | t, 4'h1, r);
      settle;
      cmp({range_low, tap_code, ref_level}, {1'b1, 4'(t), 7'(4 * t)});
    end
  endtask
  // power off, then bus refusals, with the pin routed
  task automatic t_off_refuse;
    port_a_bit2_dir <= 1'b1;
    wr(REF_CTRL_ADDR, 32'h6F, 4'h1, r);
    settle;
    cmp({pin_output_enable, port_a_bit2_pin_drive, ref_level}, 9'h100);
    wr(REF_CTRL_ADDR, 32'h00, 4'h0, r);
    cmp(r, RESP_OKAY);
    wr(12'h000, 32'hFF, 4'hF, r);
    cmp(r, RESP_SLVERR);
    wr(REF_STATUS_ADDR, 32'hFF, 4'hF, r);
    cmp(r, RESP_OKAY);
    rd(12'h000, d, r);
    cmp(d, 32'h0);
    cmp(r, RESP_SLVERR);
    rd(REF_CTRL_ADDR, d, r);
    cmp(d, 32'h6F);
  endtask
  task automatic t_reset_mid;
    wr(REF_CTRL_ADDR, 32'hE5, 4'h1, r);
    repeat (20) @(posedge mclk);
    rd(REF_CTRL_ADDR, d, r);
    cmp(d, 32'hE5);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rd(REF_CTRL_ADDR, d, r);
    cmp(d, REF_CTRL_RESET);
    cmp({ladder_power_enable, pin_output_enable, range_low, tap_code}, 0);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_fields;
    t_levels;
    t_off_refuse;
    t_reset_mid;
    close_out;
  end
  // about 320 cycles expected; cut a hang well beyond that
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    close_out;
  end
endmodule
